// ### hdl/scs_core.sv
// Byte-wide serial port, master or slave, with collision detection and a register port.
`timescale 1ns/1ps
`default_nettype none
module scs_core (
	input  wire logic                        clk,
	input  wire logic                        rst,
	input  wire logic [scs_pkg::ADDR_W-1:0]  addr,
	input  wire logic [7:0]                  wdata,
	input  wire logic                        wr,
	input  wire logic                        rd,
	output logic      [7:0]                  rdata,
	output logic                             xfer_irq,
	input  wire logic                        sck_in,
	output logic                             sck_out,
	output logic                             sck_oe,
	input  wire logic                        mosi_in,
	output logic                             mosi_out,
	output logic                             mosi_oe,
	input  wire logic                        miso_in,
	output logic                             miso_out,
	output logic                             miso_oe,
	input  wire logic                        ss_n_in
);
	import scs_pkg::*;

	scs_sync_if sync_bus ();

	scs_pin_sync u_sync (
		.clk  (clk),
		.rst  (rst),
		.pins (sync_bus)
	);

	assign sync_bus.raw = {ss_n_in, miso_in, mosi_in, sck_in};

	function automatic logic [6:0] half_period(input logic [1:0] rate, input logic dbl);
		logic [6:0] h;
		h = HALF_DIV4;
		case (rate)
			2'h0: h = dbl ? HALF_DIV2 : HALF_DIV4;
			2'h1: h = dbl ? HALF_DIV8 : HALF_DIV16;
			2'h2: h = dbl ? HALF_DIV32 : HALF_DIV64;
			2'h3: h = dbl ? HALF_DIV64 : HALF_DIV128;
			default: h = HALF_DIV4;
		endcase
		return h;
	endfunction

	function automatic logic [7:0] shift_in(input logic [7:0] sr, input logic b,
						input logic lsbf);
		return lsbf ? {b, sr[7:1]} : {sr[6:0], b};
	endfunction

	logic [7:0]  ctrl_r;
	logic [7:0]  ctrl_nxt;
	logic [1:0]  aux_r;
	logic [1:0]  aux_nxt;
	logic        done_r;
	logic        done_nxt;
	logic        write_collision_flag_r;
	logic        write_collision_flag_nxt;
	logic        arm_r;
	logic        arm_nxt;
	logic [7:0]  sr_r;
	logic [7:0]  sr_nxt;
	logic [7:0]  rxbuf_r;
	logic [7:0]  rxbuf_nxt;
	logic        samp_r;
	logic        samp_nxt;
	scs_state_t  st_r;
	scs_state_t  st_nxt;
	logic [3:0]  edge_r;
	logic [3:0]  edge_nxt;
	logic [6:0]  hcnt_r;
	logic [6:0]  hcnt_nxt;
	logic        sck_r;
	logic        sck_nxt;
	logic        sck_prev_r;
	logic [7:0]  rdata_r;
	logic [7:0]  rdata_nxt;

	logic        en;
	logic        mst;
	logic        clock_polarity_bit;
	logic        clock_phase_bit;
	logic        lsbf;
	logic        sel;
	logic        sck_clean;
	logic        wr_data;
	logic        rd_data;
	logic        rd_stat;
	logic        busy;
	logic        mode_fault;
	logic        ev;
	logic        in_bit;
	logic        sample;
	logic [6:0]  cur_half;
	logic [7:0]  rx_byte;
	logic        out_bit;

	assign en        = ctrl_r[CTRL_EN];
	assign mst       = ctrl_r[CTRL_MASTER_SELECT_BIT];
	assign clock_polarity_bit      = ctrl_r[CTRL_CLOCK_POLARITY_BIT];
	assign clock_phase_bit      = ctrl_r[CTRL_CLOCK_PHASE_BIT];
	assign lsbf      = ctrl_r[CTRL_LSBF];
	assign sel       = ~sync_bus.clean[LANE_SS_N];
	assign sck_clean = sync_bus.clean[LANE_SCK];
	assign wr_data   = wr && (addr == DATA_IDX);
	assign rd_data   = rd && (addr == DATA_IDX);
	assign rd_stat   = rd && (addr == STAT_IDX);
	assign busy      = (st_r == SCS_XFER);
	// A master with its select pin as input loses the bus when that pin goes low.
	assign mode_fault = en && mst && !aux_r[AUX_SS_OUT] && sel;
	// The rate field only shapes the master clock; a slave never reads it.
	assign cur_half  = half_period(ctrl_r[CTRL_RATE_H:CTRL_RATE_L], aux_r[AUX_DBL]);
	assign out_bit   = lsbf ? sr_r[0] : sr_r[7];
	// Phase zero samples on leading edges, phase one on trailing ones.
	assign sample    = (edge_r[0] == clock_phase_bit);

	always_comb begin
		ev     = 1'b0;
		in_bit = 1'b0;
		if (mst) begin
			in_bit = sync_bus.clean[LANE_MISO];
			ev     = busy && (hcnt_r == HALF_DIV2);
		end else begin
			in_bit = sync_bus.clean[LANE_MOSI];
			ev     = en && sel && (sck_clean != sck_prev_r);
		end
	end

	assign rx_byte = shift_in(sr_r, sample ? in_bit : samp_r, lsbf);

	always_comb begin
		ctrl_nxt  = ctrl_r;
		aux_nxt   = aux_r;
		done_nxt  = done_r;
		write_collision_flag_nxt  = write_collision_flag_r;
		arm_nxt   = arm_r;
		sr_nxt    = sr_r;
		rxbuf_nxt = rxbuf_r;
		samp_nxt  = samp_r;
		st_nxt    = st_r;
		edge_nxt  = edge_r;
		hcnt_nxt  = hcnt_r;
		sck_nxt   = sck_r;

		if (wr && (addr == CTRL_IDX)) begin
			ctrl_nxt = wdata;
		end
		if (wr && (addr == AUX_IDX)) begin
			aux_nxt = wdata[1:0];
		end

		// A status read arms the clear; the next data access then clears both flags.
		if (rd_stat) begin
			arm_nxt = 1'b1;
		end
		if ((rd_data || wr_data) && arm_r) begin
			done_nxt = 1'b0;
			write_collision_flag_nxt = 1'b0;
			arm_nxt  = 1'b0;
		end

		// Master clock: count a half period, then toggle.
		if (mst && busy) begin
			if (hcnt_r == HALF_DIV2) begin
				hcnt_nxt = cur_half;
				sck_nxt  = ~sck_r;
			end else begin
				hcnt_nxt = hcnt_r - 7'h01;
			end
		end

		if (!mst && !busy && ev) begin
			st_nxt = SCS_XFER;
		end

		if (ev) begin
			if (edge_r == LAST_EDGE) begin
				sr_nxt    = rx_byte;
				rxbuf_nxt = rx_byte;
				done_nxt  = 1'b1;
				st_nxt    = SCS_IDLE;
				edge_nxt  = EDGE_ZERO;
			end else begin
				edge_nxt = edge_r + EDGE_ONE;
				if (sample) begin
					samp_nxt = in_bit;
				end else if (edge_r != EDGE_ZERO) begin
					sr_nxt = shift_in(sr_r, samp_r, lsbf);
				end
			end
		end

		// Single buffer: a data write while idle goes straight into the shift register.
		if (wr_data) begin
			if (busy) begin
				write_collision_flag_nxt = 1'b1;
			end else begin
				sr_nxt = wdata;
				if (en && mst) begin
					st_nxt   = SCS_XFER;
					edge_nxt = EDGE_ZERO;
					hcnt_nxt = clock_phase_bit ? HALF_DIV2 : cur_half;
				end
			end
		end

		// Select released mid-byte: the slave goes idle and clears its edge count at once.
		if (!mst && busy && !sel) begin
			st_nxt   = SCS_IDLE;
			edge_nxt = EDGE_ZERO;
		end
		if (mode_fault) begin
			ctrl_nxt[CTRL_MASTER_SELECT_BIT] = 1'b0;
			st_nxt              = SCS_IDLE;
			edge_nxt            = EDGE_ZERO;
		end
		if (!en) begin
			st_nxt   = SCS_IDLE;
			edge_nxt = EDGE_ZERO;
		end
		if (st_nxt == SCS_IDLE) begin
			sck_nxt = ctrl_nxt[CTRL_CLOCK_POLARITY_BIT];
		end
	end

	always_comb begin
		rdata_nxt = 8'h00;
		if (rd) begin
			case (addr)
				CTRL_IDX: rdata_nxt = ctrl_r;
				STAT_IDX: rdata_nxt = {done_r, write_collision_flag_r, 6'h00};
				DATA_IDX: rdata_nxt = rxbuf_r;
				AUX_IDX:  rdata_nxt = {6'h00, aux_r};
				default:  rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_r     <= CTRL_RST;
			aux_r      <= AUX_RST;
			done_r     <= 1'b0;
			write_collision_flag_r     <= 1'b0;
			arm_r      <= 1'b0;
			sr_r       <= 8'h00;
			rxbuf_r    <= 8'h00;
			samp_r     <= 1'b0;
			st_r       <= SCS_IDLE;
			edge_r     <= EDGE_ZERO;
			hcnt_r     <= HALF_DIV2;
			sck_r      <= 1'b0;
			sck_prev_r <= 1'b0;
			rdata_r    <= 8'h00;
		end else begin
			ctrl_r     <= ctrl_nxt;
			aux_r      <= aux_nxt;
			done_r     <= done_nxt;
			write_collision_flag_r     <= write_collision_flag_nxt;
			arm_r      <= arm_nxt;
			sr_r       <= sr_nxt;
			rxbuf_r    <= rxbuf_nxt;
			samp_r     <= samp_nxt;
			st_r       <= st_nxt;
			edge_r     <= edge_nxt;
			hcnt_r     <= hcnt_nxt;
			sck_r      <= sck_nxt;
			sck_prev_r <= sck_clean;
			rdata_r    <= rdata_nxt;
		end
	end

	assign rdata    = rdata_r;
	assign xfer_irq = done_r && ctrl_r[CTRL_IRQ_EN];
	assign sck_out  = sck_r;
	assign sck_oe   = en && mst;
	assign mosi_out = out_bit;
	assign mosi_oe  = en && mst;
	// The slave answers only while selected, so other slaves can share the line.
	assign miso_out = out_bit;
	assign miso_oe  = en && !mst && sel;

	chk_write_collision_flag_set: assert property (@(posedge clk) disable iff (rst)
		(wr_data && busy) |=> write_collision_flag_r)
		else $error("collision flag not set by write during transfer");

	chk_sr_keep: assert property (@(posedge clk) disable iff (rst)
		(wr_data && busy && !ev && en) |=> (sr_r == $past(sr_r)))
		else $error("colliding write altered the shift register");

	chk_load_direct: assert property (@(posedge clk) disable iff (rst)
		(wr_data && !busy) |=> (sr_r == $past(wdata)))
		else $error("idle data write did not load the shift register");

	chk_off_quiet: assert property (@(posedge clk) disable iff (rst)
		!en |-> (!sck_oe && !mosi_oe && !miso_oe) ##1 !busy)
		else $error("disabled port still active");

	chk_fast_clock: assert property (@(posedge clk) disable iff (rst)
		(mst && busy && en && cur_half == HALF_DIV2 && hcnt_r == HALF_DIV2 && !mode_fault)
		|=> (sck_r != $past(sck_r)))
		else $error("master clock missed a half period");

	chk_byte_done: assert property (@(posedge clk) disable iff (rst)
		(ev && edge_r == LAST_EDGE) |=> (done_r && rxbuf_r == $past(rx_byte) && !busy))
		else $error("completed byte not flagged or not buffered");

	chk_ss_abort: assert property (@(posedge clk) disable iff (rst)
		(!mst && busy && !sel) |=> !busy)
		else $error("slave kept running after select release");

	chk_flag_clear: assert property (@(posedge clk) disable iff (rst)
		(arm_r && rd_data && !(ev && edge_r == LAST_EDGE)) |=> (!done_r && !write_collision_flag_r))
		else $error("flag clear sequence failed");

	chk_mode_fault: assert property (@(posedge clk) disable iff (rst)
		mode_fault |=> (!ctrl_r[CTRL_MASTER_SELECT_BIT] && !busy && !sck_oe))
		else $error("master did not yield on select low");
endmodule
`default_nettype wire

// ### common/scs_pkg.sv
// Package with register map, field positions and timing constants of the serial port.
package scs_pkg;
	localparam int ADDR_W = 2;
	localparam logic [1:0] CTRL_IDX = 2'h0;
	localparam logic [1:0] STAT_IDX = 2'h1;
	localparam logic [1:0] DATA_IDX = 2'h2;
	localparam logic [1:0] AUX_IDX  = 2'h3;

	// Control register fields.
	localparam int CTRL_IRQ_EN = 7;
	localparam int CTRL_EN     = 6;
	localparam int CTRL_LSBF   = 5;
	localparam int CTRL_MASTER_SELECT_BIT   = 4;
	localparam int CTRL_CLOCK_POLARITY_BIT   = 3;
	localparam int CTRL_CLOCK_PHASE_BIT   = 2;
	localparam int CTRL_RATE_H = 1;
	localparam int CTRL_RATE_L = 0;
	localparam logic [7:0] CTRL_RST = 8'h00;

	// Status register fields.
	localparam int STAT_DONE = 7;
	localparam int STAT_WRITE_COLLISION_FLAG = 6;

	// Auxiliary register fields.
	localparam int AUX_SS_OUT = 0;
	localparam int AUX_DBL    = 1;
	localparam logic [1:0] AUX_RST = 2'h0;

	// Half periods of the master serial clock, in core clock cycles minus one.
	localparam logic [6:0] HALF_DIV2   = 7'h00;
	localparam logic [6:0] HALF_DIV4   = 7'h01;
	localparam logic [6:0] HALF_DIV8   = 7'h03;
	localparam logic [6:0] HALF_DIV16  = 7'h07;
	localparam logic [6:0] HALF_DIV32  = 7'h0f;
	localparam logic [6:0] HALF_DIV64  = 7'h1f;
	localparam logic [6:0] HALF_DIV128 = 7'h3f;

	localparam logic [3:0] LAST_EDGE = 4'hf;
	localparam logic [3:0] EDGE_ZERO = 4'h0;
	localparam logic [3:0] EDGE_ONE  = 4'h1;

	// Synchroniser lanes and their reset levels.
	localparam int SYNC_W    = 4;
	localparam int LANE_SCK  = 0;
	localparam int LANE_MOSI = 1;
	localparam int LANE_MISO = 2;
	localparam int LANE_SS_N = 3;
	localparam logic [3:0] SYNC_RST = 4'h8;

	typedef enum logic {
		SCS_IDLE = 1'b0,
		SCS_XFER = 1'b1
	} scs_state_t;
endpackage

// ### common/scs_sync_if.sv
// Interface that carries raw pin levels to the synchroniser and clean levels back.
`timescale 1ns/1ps
`default_nettype none
interface scs_sync_if;
	logic [scs_pkg::SYNC_W-1:0] raw;
	logic [scs_pkg::SYNC_W-1:0] clean;
	modport src  (output raw, input clean);
	modport sync (input raw, output clean);
endinterface
`default_nettype wire

// ### hdl/scs_pin_sync.sv
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module scs_pin_sync (
	input  wire logic clk,
	input  wire logic rst,
	scs_sync_if.sync  pins
);
	import scs_pkg::*;

	logic [SYNC_W-1:0] s1_r;
	logic [SYNC_W-1:0] s2_r;
	logic [SYNC_W-1:0] s3_r;
	logic [SYNC_W-1:0] clean_r;
	logic [SYNC_W-1:0] clean_nxt;

	always_comb begin
		clean_nxt = clean_r;
		for (int i = 0; i < SYNC_W; i++) begin
			if (s2_r[i] == s3_r[i]) begin
				clean_nxt[i] = s3_r[i];
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_r    <= SYNC_RST;
			s2_r    <= SYNC_RST;
			s3_r    <= SYNC_RST;
			clean_r <= SYNC_RST;
		end else begin
			s1_r    <= pins.raw;
			s2_r    <= s1_r;
			s3_r    <= s2_r;
			clean_r <= clean_nxt;
		end
	end

	assign pins.clean = clean_r;
endmodule
`default_nettype wire

// ### dv/scs_remote_slave.sv
// Behavioural remote slave in mode zero, most significant bit first.
`timescale 1ns/1ps
`default_nettype none
module scs_remote_slave (
	input  wire logic       sck,
	input  wire logic       mosi,
	input  wire logic       sel_n,
	input  wire logic [7:0] load,
	output logic      [7:0] got,
	output logic            miso
);
	logic [7:0] sh_r;
	logic       last_r = 1'b0;
	logic       sel_q = 1'b1;
	logic       sck_q = 1'b0;
	// A released line shows the inverse of its last bit, so a stale level never passes.
	assign miso = sel_n ? ~last_r : sh_r[7];
	// One process owns every register of the model, so each has a single driver.
	always @(sel_n or sck) begin
		if (!sel_n && sel_q) begin
			sh_r = load;
			got = 8'h00;
		end else if (!sel_n && sck && !sck_q) begin
			got = {got[6:0], mosi};
		end else if (!sel_n && !sck && sck_q) begin
			last_r = sh_r[7];
			sh_r = {sh_r[6:0], 1'b0};
		end
		sel_q = sel_n;
		sck_q = sck;
	end
endmodule
`default_nettype wire

// ### dv/spi_collision_and_setup_bench.sv
// Self-checking bench for the serial port against a remote slave model.
`timescale 1ns/1ps
`default_nettype none
module spi_collision_and_setup_bench;
	import scs_pkg::*;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic [1:0] addr = 2'h0;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic       tb_sck = 1'b0;
	logic       tb_mosi = 1'b0;
	logic       ss_n = 1'b1;
	logic       p_sel_n = 1'b1;
	logic [7:0] p_load = 8'h3c;
	wire  [7:0] rdata;
	wire  [7:0] p_got;
	wire        xfer_irq, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, p_miso;
	wire        sck_w = sck_oe ? sck_out : tb_sck;
	wire        mosi_w = mosi_oe ? mosi_out : tb_mosi;
	wire        miso_w = miso_oe ? miso_out : p_miso;
	int         bad_count = 0;
	int         total_checks = 0;
	logic [7:0] v;
	int         n;

	always #20 clk = ~clk;

	scs_core i_scs_core (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .xfer_irq(xfer_irq), .sck_in(sck_w), .sck_out(sck_out),
		.sck_oe(sck_oe), .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
		.miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(ss_n));
	scs_remote_slave i_scs_remote_slave (.sck(sck_w), .mosi(mosi_w), .sel_n(p_sel_n),
		.load(p_load), .got(p_got), .miso(p_miso));

	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic idle(input int c);
		repeat (c) @(posedge clk);
	endtask
	task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
	task automatic wait_done(output logic [7:0] s);
		int i;
		s = 8'h00;
		for (i = 0; i < 100 && s[STAT_DONE] !== 1'b1; i++) rd_reg(STAT_IDX, s);
	endtask
	// Counts core cycles between the first and second serial clock toggles.
	task automatic half_time(output int c);
		logic p;
		int i;
		c = 0;
		@(negedge clk);
		p = sck_out;
		for (i = 0; i < 50 && sck_out === p; i++) @(negedge clk);
		p = sck_out;
		while (sck_out === p && c < 50) begin
			@(negedge clk);
			c++;
		end
	endtask
	// Plays a remote master in mode zero; a slow clock keeps the slave's sync delay covered.
	task automatic sbits(input logic [7:0] tx, input int nb, input int wr_at,
			output logic [7:0] cap);
		int b;
		cap = 8'h00;
		for (b = 0; b < nb; b++) begin
			tb_mosi <= tx[7-b];
			idle(8);
			tb_sck <= 1'b1;
			// A write asked for at this bit lands after the rising edge has reached the core.
			idle(4);
			if (b == wr_at) wr_reg(DATA_IDX, 8'hff);
			idle(4);
			cap = {cap[6:0], miso_w};
			tb_sck <= 1'b0;
		end
	endtask

	task automatic t_reset;
		rd_reg(CTRL_IDX, v);
		chk8(v, CTRL_RST, "control after reset");
		rd_reg(STAT_IDX, v);
		chk8(v, 8'h00, "status after reset");
	endtask
	task automatic t_rates;
		logic [7:0] aux_t [3] = '{8'h01, 8'h01, 8'h03};
		logic [7:0] ctl_t [3] = '{8'h50, 8'h51, 8'h50};
		logic [7:0] hlf_t [3] = '{8'h02, 8'h08, 8'h01};
		int k;
		for (k = 0; k < 3; k++) begin
			wr_reg(AUX_IDX, aux_t[k]);
			wr_reg(CTRL_IDX, ctl_t[k]);
			rd_reg(CTRL_IDX, v);
			chk8(v, ctl_t[k], "master bit before start");
			wr_reg(DATA_IDX, 8'h81);
			half_time(n);
			chk8(8'(n), hlf_t[k], "clock half period");
			wait_done(v);
			chk8(v, 8'h80, "status after byte");
			rd_reg(DATA_IDX, v);
		end
	endtask
	task automatic t_master;
		p_load <= 8'h3c;
		p_sel_n <= 1'b0;
		wr_reg(AUX_IDX, 8'h01);
		wr_reg(CTRL_IDX, 8'hd1);
		wr_reg(DATA_IDX, 8'ha5);
		idle(20);
		wr_reg(DATA_IDX, 8'h0f);
		wait_done(v);
		chk8(v, 8'hc0, "status after collision");
		chk8({7'h00, xfer_irq}, 8'h01, "irq raised");
		chk8(p_got, 8'ha5, "byte at remote");
		rd_reg(DATA_IDX, v);
		chk8(v, 8'h3c, "received byte");
		rd_reg(STAT_IDX, v);
		chk8(v, 8'h00, "flags after clear");
		chk8({7'h00, xfer_irq}, 8'h00, "irq after clear");
		p_sel_n <= 1'b1;
	endtask
	task automatic t_disable;
		wr_reg(CTRL_IDX, 8'h58);
		@(negedge clk);
		chk8({7'h00, sck_out}, 8'h01, "clock idles at polarity");
		wr_reg(CTRL_IDX, 8'h11);
		wr_reg(DATA_IDX, 8'h77);
		idle(200);
		rd_reg(STAT_IDX, v);
		chk8(v, 8'h00, "no transfer when off");
		chk8({7'h00, sck_oe}, 8'h00, "clock not driven when off");
	endtask
	task automatic t_slave;
		logic [7:0] cap;
		wr_reg(CTRL_IDX, 8'h43);
		ss_n <= 1'b0;
		wr_reg(DATA_IDX, 8'h5a);
		idle(8);
		sbits(8'hc3, 8, 0, cap);
		idle(8);
		rd_reg(STAT_IDX, v);
		chk8(v, 8'hc0, "slave done with collision");
		chk8(cap, 8'h5a, "slave sent byte");
		rd_reg(DATA_IDX, v);
		chk8(v, 8'hc3, "slave received byte");
		sbits(8'hf0, 4, 9, cap);
		ss_n <= 1'b1;
		idle(20);
		rd_reg(STAT_IDX, v);
		chk8(v, 8'h00, "aborted byte");
		// A fresh byte after the abort only lines up if the edge count was cleared.
		wr_reg(CTRL_IDX, 8'h63);
		wr_reg(DATA_IDX, 8'h1e);
		ss_n <= 1'b0;
		idle(8);
		sbits(8'h2d, 8, 9, cap);
		idle(8);
		rd_reg(STAT_IDX, v);
		chk8(v, 8'h80, "byte after abort");
		chk8(cap, 8'h78, "low bit first out");
		rd_reg(DATA_IDX, v);
		chk8(v, 8'hb4, "low bit first in");
		idle(1);
		ss_n <= 1'b1;
		idle(8);
	endtask
	task automatic t_fault;
		wr_reg(AUX_IDX, 8'h00);
		wr_reg(CTRL_IDX, 8'h50);
		ss_n <= 1'b0;
		idle(8);
		rd_reg(CTRL_IDX, v);
		chk8(v, 8'h40, "master dropped to slave");
	endtask

	initial begin
		idle(20);
		rst <= 1'b0;
		t_reset;
		t_rates;
		t_master;
		t_disable;
		t_slave;
		t_fault;
		end_sim;
	end
	// The sequence needs well under ten thousand cycles; this limit only cuts a hang.
	initial begin
		#2000000;
		bad_count++;
		end_sim;
	end
endmodule
`default_nettype wire
